// ### design/oinh_top.sv
// Notes on behaviour
// - File version is 32-bit little-endian; top byte compatibility, low three firmware version.
// - After header, sub-elements: 2-byte tag, 4-byte length n, n data bytes.
// - Sub-element tag 0x0000 marks the upgrade image, firmware or file system.
// - Upgrade packets use endpoints 0xE8, cluster 0x0019, profile 0xC105.
// - First three payload bytes name the command; integers are little-endian.
// - Valid unicast notify gets a query request; mismatched optional field gets default response.
// - Broadcast notify answered only when optional fields show a compatible image.
// - Jitter 0..100, 100 for unicast; broadcast replies only if random below jitter.
// - Image Notify uses command 0x00 in third byte; sequence number free.
// - Payload type 0..3 adds manufacturer, image type, then file version.
// - Jitter at offset 4, manufacturer 5, image type 7, file version 9.
// - Client drives upgrade with requests; retries limited times then aborts.
// - Image type 0x0000 means firmware, 0x0100 means file system.
// - Reply to a valid notify uses command 0x01, Query Next Image Request.
`timescale 1ns/10ps
`default_nettype none
module oinh_top #(
  parameter logic [15:0] MFG_CODE     = 16'h1234, // Arbitrary value
  parameter logic [15:0] IMG_TYPE     = 16'h0000,
  parameter logic [31:0] CUR_VERSION  = 32'h01000001,
  parameter int          TIMEOUT_CYC  = oinh_pkg::RESP_TIMEOUT,
  parameter int          RETRIES      = oinh_pkg::RETRY_MAX
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_LAST,
  input  wire logic        RX_BCAST,
  input  wire logic [7:0]  RX_SRC_EP,
  input  wire logic [7:0]  RX_DST_EP,
  input  wire logic [15:0] RX_CLUSTER,
  input  wire logic [15:0] RX_PROFILE,
  input  wire logic        RESP_SEEN,
  output logic             TX_QUERY,
  output logic             TX_DEFAULT,
  output logic      [7:0]  TX_FC,
  output logic      [7:0]  TX_SEQ,
  output logic      [7:0]  TX_CMD,
  output logic      [7:0]  TX_EP,
  output logic      [15:0] TX_CLUSTER,
  output logic      [15:0] TX_PROFILE,
  output logic      [15:0] TX_IMG_TYPE,
  output logic      [31:0] TX_VERSION,
  output logic      [7:0]  CUR_COMPAT,
  output logic      [23:0] CUR_FW_VER,
  output logic             UPG_ACTIVE,
  output logic             UPG_ABORT
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DRAW = 2'b01,
    S_WAIT = 2'b10
  } oinh_state_t;

  oinh_state_t state_q;
  logic [3:0]  idx_q;
  logic [7:0]  fc_q, seq_q, cmd_q, ptype_q, jit_q;
  logic [15:0] mfg_q, img_q;
  logic [31:0] ver_q;
  logic        addr_ok_q, bcast_q, draw;
  logic        len_ok_q;
  logic [6:0]  rnd;
  logic [31:0] tmo_q;
  logic [3:0]  try_q;

  // Little-endian byte placement into a field
  function automatic logic [31:0] le_put(input logic [31:0] f, input logic [7:0] b,
                                         input int pos);
    logic [31:0] r;
    r = f;
    r[pos*8 +: 8] = b;
    return r;
  endfunction : le_put

  // Optional fields checked only if present by payload type
  function automatic logic fields_ok(input logic [7:0] pt, input logic [15:0] m,
                                     input logic [15:0] it, input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    if (pt >= 8'h01 && m != MFG_CODE) ok = 1'b0;
    if (pt >= 8'h02 && it != IMG_TYPE) ok = 1'b0;
    if (pt >= 8'h03 && v[31:24] != CUR_VERSION[31:24]) ok = 1'b0;
    if (pt > 8'h03) ok = 1'b0;
    return ok;
  endfunction : fields_ok

  oinh_lfsr u_rng (
    .clk   (SYS_CLK),
    .rst   (RST),
    .step  (draw),
    .rnd_q (rnd)
  );

  logic last_byte, cmd_ok, opt_ok;
  assign last_byte = RX_VALID && RX_LAST;
  assign cmd_ok    = addr_ok_q && cmd_q == oinh_pkg::CMD_NOTIFY
                     && len_ok_q;
  assign opt_ok    = fields_ok(ptype_q, mfg_q, img_q, ver_q);
  assign draw      = state_q == S_IDLE && last_byte && bcast_q;

  // Byte collector; multi-byte fields little-endian
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      idx_q <= 4'h0; fc_q <= 8'h00; seq_q <= 8'h00; cmd_q <= 8'hFF;
      ptype_q <= 8'h00; jit_q <= 8'h00; mfg_q <= 16'h0000; img_q <= 16'h0000;
      ver_q <= 32'h0; addr_ok_q <= 1'b0; bcast_q <= 1'b0;
      len_ok_q <= 1'b0;
    end else if (RX_VALID) begin
      if (idx_q == 4'h0) begin
        addr_ok_q <= RX_SRC_EP == oinh_pkg::SRC_EP && RX_DST_EP == oinh_pkg::DST_EP
                     && RX_CLUSTER == oinh_pkg::CLUSTER_ID
                     && RX_PROFILE == oinh_pkg::PROFILE_ID;
        bcast_q <= RX_BCAST;
      end
      case (int'(idx_q))
        oinh_pkg::OFS_FC:     fc_q    <= RX_DATA;
        oinh_pkg::OFS_SEQ:    seq_q   <= RX_DATA;
        oinh_pkg::OFS_CMD:    cmd_q   <= RX_DATA;
        oinh_pkg::OFS_PTYPE:  ptype_q <= RX_DATA;
        oinh_pkg::OFS_JITTER: jit_q   <= RX_DATA;
        5, 6:                 mfg_q   <= 16'(le_put({16'h0, mfg_q}, RX_DATA, int'(idx_q) - 5));
        7, 8:                 img_q   <= 16'(le_put({16'h0, img_q}, RX_DATA, int'(idx_q) - 7));
        9, 10, 11, 12:        ver_q   <= le_put(ver_q, RX_DATA, int'(idx_q) - 9);
        default:              ;
      endcase
      // Length judged on the last byte, since the index restarts there
      if (RX_LAST) begin
        idx_q    <= 4'h0;
        len_ok_q <= idx_q >= 4'(oinh_pkg::OFS_JITTER);
      end else if (idx_q != 4'hF) begin
        idx_q <= idx_q + 4'h1;
      end
    end
  end

  logic pkt_done_q;
  always_ff @(posedge SYS_CLK) begin
    if (RST) pkt_done_q <= 1'b0;
    else pkt_done_q <= last_byte;
  end

  // Decision, response timing and retry bookkeeping
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= S_IDLE; TX_QUERY <= 1'b0; TX_DEFAULT <= 1'b0;
      UPG_ACTIVE <= 1'b0; UPG_ABORT <= 1'b0; tmo_q <= 32'h0; try_q <= 4'h0;
      TX_SEQ <= 8'h00; TX_FC <= oinh_pkg::FC_CLIENT_CMD; TX_CMD <= oinh_pkg::CMD_QUERY;
    end else begin
      TX_QUERY   <= 1'b0;
      TX_DEFAULT <= 1'b0;
      UPG_ABORT  <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (pkt_done_q && cmd_ok) begin
            if (!bcast_q) begin
              TX_SEQ <= seq_q;
              if (opt_ok) begin
                TX_QUERY <= 1'b1;
                TX_CMD <= oinh_pkg::CMD_QUERY;
                UPG_ACTIVE <= 1'b1; state_q <= S_WAIT; tmo_q <= 32'h0; try_q <= 4'h0;
              end else begin
                TX_DEFAULT <= 1'b1;
                TX_CMD <= oinh_pkg::CMD_NOTIFY;
              end
            end else begin
              state_q <= S_DRAW;
            end
          end
        end
        S_DRAW: begin
          state_q <= S_IDLE;
          // Silent on mismatch or a losing draw
          if (opt_ok && {1'b0, rnd} < jit_q && jit_q <= oinh_pkg::JITTER_MAX) begin
            TX_SEQ <= seq_q; TX_QUERY <= 1'b1; TX_CMD <= oinh_pkg::CMD_QUERY;
            UPG_ACTIVE <= 1'b1; state_q <= S_WAIT; tmo_q <= 32'h0; try_q <= 4'h0;
          end
        end
        S_WAIT: begin
          if (RESP_SEEN) begin
            tmo_q <= 32'h0; try_q <= 4'h0;
          end else if (tmo_q == 32'(TIMEOUT_CYC - 1)) begin
            tmo_q <= 32'h0;
            if (try_q == 4'(RETRIES)) begin
              UPG_ABORT <= 1'b1; UPG_ACTIVE <= 1'b0; state_q <= S_IDLE;
            end else begin
              try_q <= try_q + 4'h1; TX_QUERY <= 1'b1;
            end
          end else begin
            tmo_q <= tmo_q + 32'h1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Fixed addressing and current version reporting
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      TX_EP <= 8'h00; TX_CLUSTER <= 16'h0; TX_PROFILE <= 16'h0;
      TX_IMG_TYPE <= 16'h0; TX_VERSION <= 32'h0; CUR_COMPAT <= 8'h00; CUR_FW_VER <= 24'h0;
    end else begin
      TX_EP <= oinh_pkg::SRC_EP; TX_CLUSTER <= oinh_pkg::CLUSTER_ID;
      TX_PROFILE <= oinh_pkg::PROFILE_ID;
      TX_IMG_TYPE <= IMG_TYPE; TX_VERSION <= CUR_VERSION;
      CUR_COMPAT <= CUR_VERSION[31:24]; CUR_FW_VER <= CUR_VERSION[23:0];
    end
  end

  a_unicast_reply: assert property (@(posedge SYS_CLK) disable iff (RST)
    state_q == S_IDLE && pkt_done_q && cmd_ok && !bcast_q |=> TX_QUERY ^ TX_DEFAULT)
    else $error("unicast notify not answered");
  a_bcast_silent: assert property (@(posedge SYS_CLK) disable iff (RST)
    state_q == S_DRAW && !opt_ok |=> !TX_QUERY && !TX_DEFAULT)
    else $error("broadcast mismatch answered");
  a_jitter_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    state_q == S_DRAW && {1'b0, rnd} >= jit_q |=> !TX_QUERY)
    else $error("jitter gate failed");
  a_query_cmd: assert property (@(posedge SYS_CLK) disable iff (RST)
    TX_QUERY |-> TX_CMD == oinh_pkg::CMD_QUERY && TX_FC == oinh_pkg::FC_CLIENT_CMD)
    else $error("query command id wrong");
  a_abort_ends: assert property (@(posedge SYS_CLK) disable iff (RST)
    UPG_ABORT |-> !UPG_ACTIVE && state_q == S_IDLE)
    else $error("abort did not end upgrade");
  a_no_default_bc: assert property (@(posedge SYS_CLK) disable iff (RST)
    TX_DEFAULT |-> $past(!bcast_q) && $past(cmd_q) == oinh_pkg::CMD_NOTIFY)
    else $error("default response wrongly sent");
  a_seq_echo: assert property (@(posedge SYS_CLK) disable iff (RST)
    state_q == S_IDLE && pkt_done_q && cmd_ok && !bcast_q |=> TX_SEQ == $past(seq_q))
    else $error("sequence not echoed");
  a_addr_fixed: assert property (@(posedge SYS_CLK) disable iff (RST)
    $past(!RST) |-> TX_EP == 8'hE8 && TX_CLUSTER == 16'h0019 && TX_PROFILE == 16'hC105)
    else $error("addressing wrong");
endmodule : oinh_top
`default_nettype wire

// ### design/oinh_pkg.sv
`default_nettype none
package oinh_pkg;
  localparam logic [7:0]  SRC_EP        = 8'hE8;
  localparam logic [7:0]  DST_EP        = 8'hE8;
  localparam logic [15:0] CLUSTER_ID    = 16'h0019;
  localparam logic [15:0] PROFILE_ID    = 16'hC105;
  localparam logic [7:0]  FC_UNICAST    = 8'h09;
  localparam logic [7:0]  FC_BROADCAST  = 8'h19;
  localparam logic [7:0]  FC_CLIENT_CMD = 8'h01;
  localparam logic [7:0]  CMD_NOTIFY    = 8'h00;
  localparam logic [7:0]  CMD_QUERY     = 8'h01;
  localparam logic [7:0]  JITTER_MAX    = 8'h64;
  localparam logic [15:0] TAG_IMAGE     = 16'h0000;
  localparam logic [15:0] IMG_FIRMWARE  = 16'h0000;
  localparam logic [15:0] IMG_FILESYS   = 16'h0100;
  localparam int          OFS_FC        = 0;
  localparam int          OFS_SEQ       = 1;
  localparam int          OFS_CMD       = 2;
  localparam int          OFS_PTYPE     = 3;
  localparam int          OFS_JITTER    = 4;
  localparam int          OFS_MFG       = 5;
  localparam int          OFS_IMG       = 7;
  localparam int          OFS_VER       = 9;
  localparam int          NOTIFY_LEN    = 13;
  localparam int          TLV_HDR_LEN   = 6;
  localparam int          RETRY_MAX     = 3;
  localparam int          RESP_TIMEOUT  = 40000;
endpackage : oinh_pkg
`default_nettype wire

// ### design/oinh_lfsr.sv
`timescale 1ns/10ps
`default_nettype none
module oinh_lfsr (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       step,
  output logic      [6:0] rnd_q
);
  logic [15:0] lfsr_q;
  logic [6:0]  low_d;

  always_comb begin
    low_d = lfsr_q[6:0];
    if (low_d > 7'h63) begin
      low_d = low_d - 7'h64;
    end
  end

  // Fold 0..127 into 0..99; slight bias on low values traded for one-cycle draws
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_q <= 16'hACE1;
      rnd_q  <= 7'h00;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      if (step) begin
        rnd_q <= low_d;
      end
    end
  end
endmodule : oinh_lfsr
`default_nettype wire

// ### verif/oinh_server_model.sv
`timescale 1ns/10ps
`default_nettype none
module oinh_server_model (
  input  wire logic        clk,
  output var  logic        rx_valid,
  output var  logic [7:0]  rx_data,
  output var  logic        rx_last,
  output var  logic        rx_bcast,
  output var  logic [7:0]  rx_src_ep,
  output var  logic [7:0]  rx_dst_ep,
  output var  logic [15:0] rx_cluster,
  output var  logic [15:0] rx_profile
);
  logic [7:0] pkt [0:12];
  initial begin
    {rx_valid, rx_last, rx_bcast} = 3'h0;
    rx_data = 8'hA5;
    rx_src_ep = oinh_pkg::SRC_EP;
    rx_dst_ep = oinh_pkg::DST_EP;
    rx_cluster = oinh_pkg::CLUSTER_ID;
    rx_profile = oinh_pkg::PROFILE_ID;
  end
  // Stateless: each notify is built from the arguments alone
  task automatic send(input logic bc, input logic bad, input logic [7:0] seq,
                      input logic [7:0] pt, input logic [7:0] jit, input logic [15:0] mfg,
                      input logic [15:0] img, input logic [31:0] ver);
    int n;
    n = (pt == 8'h00) ? 5 : (pt == 8'h01) ? 7 : (pt == 8'h02) ? 9 : 13;
    pkt[0] = bc ? oinh_pkg::FC_BROADCAST : oinh_pkg::FC_UNICAST;
    pkt[1] = seq;
    pkt[2] = oinh_pkg::CMD_NOTIFY;
    pkt[3] = pt;
    pkt[4] = jit;
    {pkt[6], pkt[5]} = mfg;
    {pkt[8], pkt[7]} = img;
    {pkt[12], pkt[11], pkt[10], pkt[9]} = ver;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= pkt[i];
      rx_last <= (i == n - 1);
      rx_bcast <= bc;
      rx_cluster <= bad ? 16'h0018 : oinh_pkg::CLUSTER_ID;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    // Released line must not keep showing the last byte
    rx_data <= ~pkt[n - 1];
  endtask : send
endmodule : oinh_server_model
`default_nettype wire

// ### verif/ota_image_notify_handler_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ota_image_notify_handler_tb;
  localparam logic [15:0] MFG = 16'h1234;
  localparam logic [15:0] IMG = 16'h0100;
  localparam logic [31:0] VER = 32'h0200300B;
  localparam int          TMO = 20;
  localparam int          RET = 3;
  logic clk = 1'b0, rst = 1'b1, resp_seen = 1'b0;
  logic rx_valid, rx_last, rx_bcast, tx_query, tx_default, upg_active, upg_abort;
  logic [7:0] rx_data, rx_src_ep, rx_dst_ep, tx_fc, tx_seq, tx_cmd, tx_ep, cur_compat;
  logic [15:0] rx_cluster, rx_profile, tx_cluster, tx_profile, tx_img_type;
  logic [31:0] tx_version;
  logic [23:0] cur_fw_ver;
  int fail_count = 0, num_checks = 0, seed = 77808;
  logic r_bc, r_bad;
  logic [7:0] r_pt, r_jit;
  always #25 clk = ~clk;
  oinh_server_model oinh_server_model_inst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_bcast(rx_bcast), .rx_src_ep(rx_src_ep), .rx_dst_ep(rx_dst_ep),
    .rx_cluster(rx_cluster), .rx_profile(rx_profile));
  oinh_top #(.MFG_CODE(MFG), .IMG_TYPE(IMG), .CUR_VERSION(VER), .TIMEOUT_CYC(TMO), .RETRIES(RET))
  oinh_top_inst (.SYS_CLK(clk), .RST(rst), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_LAST(rx_last), .RX_BCAST(rx_bcast), .RX_SRC_EP(rx_src_ep), .RX_DST_EP(rx_dst_ep),
    .RX_CLUSTER(rx_cluster), .RX_PROFILE(rx_profile), .RESP_SEEN(resp_seen),
    .TX_QUERY(tx_query), .TX_DEFAULT(tx_default), .TX_FC(tx_fc), .TX_SEQ(tx_seq),
    .TX_CMD(tx_cmd), .TX_EP(tx_ep), .TX_CLUSTER(tx_cluster), .TX_PROFILE(tx_profile),
    .TX_IMG_TYPE(tx_img_type), .TX_VERSION(tx_version), .CUR_COMPAT(cur_compat),
    .CUR_FW_VER(cur_fw_ver), .UPG_ACTIVE(upg_active), .UPG_ABORT(upg_abort));
  task automatic close_out;
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : chk
  // 0 silent, 1 query, 2 default response
  function automatic int expect_kind(input logic bc, input logic bad, input logic [7:0] pt,
      input logic [7:0] jit, input logic [15:0] m, input logic [15:0] t, input logic [31:0] v);
    bit ok;
    if (bad) return 0;
    // Unicast ignores jitter; an unknown payload type is invalid information
    ok = pt <= 8'h03 && (pt < 1 || m == MFG) && (pt < 2 || t == IMG)
         && (pt < 3 || v[31:24] == VER[31:24]);
    if (!bc) return ok ? 1 : 2;
    return (ok && jit == 8'h64) ? 1 : 0;
  endfunction : expect_kind
  task automatic trial(input logic bc, input logic bad, input logic [7:0] seq,
      input logic [7:0] pt, input logic [7:0] jit, input logic [15:0] m, input logic [15:0] t,
      input logic [31:0] v);
    int k, q_at, d_at, n_ret, ab_at;
    k = expect_kind(bc, bad, pt, jit, m, t, v);
    q_at = 0;
    d_at = 0;
    oinh_server_model_inst.send(bc, bad, seq, pt, jit, m, t, v);
    for (int c = 1; c <= 5; c++) begin
      @(posedge clk);
      #1;
      if (tx_query === 1'b1) q_at = c;
      if (tx_default === 1'b1) d_at = c;
    end
    chk(q_at == ((k == 1) ? (bc ? 2 : 1) : 0), "query pulse");
    chk(d_at == ((k == 2) ? 1 : 0), "default pulse");
    if (k == 2) chk(tx_cmd === 8'h00 && tx_seq === seq, "default cmd");
    if (k == 1) begin
      chk(tx_cmd === 8'h01 && tx_fc === 8'h01 && tx_seq === seq, "query fields");
      chk(upg_active === 1'b1, "not active");
      n_ret = 0;
      ab_at = 0;
      for (int c = 1; c <= 200 && ab_at == 0; c++) begin
        @(posedge clk);
        resp_seen <= (c == 10);
        #1;
        if (tx_query === 1'b1) n_ret++;
        if (upg_abort === 1'b1) ab_at = c;
      end
      chk(ab_at != 0 && n_ret == RET, "retry count or abort");
      // Response seen at edge 11 restarts the count: all retries then time out
      chk(ab_at == 11 + (RET + 1) * TMO, "abort timing");
      chk(upg_active === 1'b0, "still active after abort");
    end
  endtask : trial
  initial begin
    #(50 * 30000);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    chk(upg_active === 1'b0 && tx_query === 1'b0, "reset state");
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(tx_ep === 8'hE8 && tx_cluster === 16'h0019 && tx_profile === 16'hC105, "addr");
    chk(cur_compat === 8'h02 && cur_fw_ver === 24'h00300B, "version split");
    chk(tx_img_type === 16'h0100 && tx_version === VER, "image type");
    trial(0, 0, 8'h01, 8'h03, 8'h64, MFG, IMG, VER);
    trial(0, 0, 8'h5A, 8'h01, 8'h64, ~MFG, IMG, VER);
    trial(0, 0, 8'h07, 8'h03, 8'h64, MFG, IMG, {8'h01, VER[23:0]});
    trial(1, 0, 8'h02, 8'h02, 8'h64, MFG, 16'h0000, VER);
    trial(1, 0, 8'h03, 8'h00, 8'h00, MFG, IMG, VER);
    trial(1, 0, 8'h04, 8'h03, 8'h64, MFG, IMG, VER);
    trial(0, 1, 8'h05, 8'h00, 8'h64, MFG, IMG, VER);
    trial(0, 0, 8'h06, 8'h04, 8'h64, MFG, IMG, VER);
    trial(0, 0, 8'h08, 8'h00, 8'h65, MFG, IMG, VER);
    repeat (24) begin
      r_bc = 1'($random(seed));
      r_bad = ({$random(seed)} % 8) == 0;
      r_pt = 8'({$random(seed)} % 5);
      r_jit = r_bc ? 8'(($random(seed) & 1) * 8'h64) : 8'(8'h64 + (({$random(seed)} % 6) == 0));
      trial(r_bc, r_bad, 8'($random(seed)), r_pt, r_jit, ($random(seed) & 3) ? MFG : ~MFG,
            ($random(seed) & 3) ? IMG : ~IMG, {($random(seed) & 3) ? VER[31:24] : 8'h05,
            24'($random(seed))});
    end
    close_out();
  end
endmodule : ota_image_notify_handler_tb
`default_nettype wire
